// >>> logic/usbi_pkg.sv
// Purpose: shared constants of the usb interrupt enable and error status block
// Assumes: byte-wide registers reached over a plain strobe port
// Notes: offsets are register indices on a 4-bit address
package usbi_pkg;
  localparam int REG_W = 8;
  localparam int ADDR_W = 4;
  // register indices
  localparam logic [ADDR_W-1:0] OFF_STAT_FLAG = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_STAT_EN = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_ERR_FLAG = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_ERR_EN = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_EVT = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_EVT_MASK = 4'h5;
  // reset value of every register
  localparam logic [REG_W-1:0] REG_RST = 8'h00;
  // status flag and enable positions
  localparam int ST_SOF = 6;
  localparam int ST_STALL = 5;
  localparam int ST_IDLE = 4;
  localparam int ST_TRN = 3;
  localparam int ST_ACTV = 2;
  localparam int ST_ERR = 1;
  localparam int ST_URST = 0;
  // error flag and enable positions
  localparam int ER_STUFF = 7;
  localparam int ER_TURN = 4;
  localparam int ER_ALIGN = 3;
  localparam int ER_CRC16 = 2;
  localparam int ER_CRC5 = 1;
  localparam int ER_PID = 0;
  // implemented bits
  localparam logic [REG_W-1:0] STAT_EN_MASK = 8'h7f;
  localparam logic [REG_W-1:0] STAT_FLAG_MASK = 8'h7d;
  localparam logic [REG_W-1:0] ERR_MASK = 8'h9f;
  localparam logic [REG_W-1:0] EVT_MASK = 8'h07;
  // event register positions
  localparam int EV_STAT = 0;
  localparam int EV_ERR = 1;
  localparam int EV_REQ = 2;
endpackage

// >>> logic/usbi_flag_bank.sv
// Purpose: bank of sticky flags set by engine pulses and cleared by firmware zeros
// Assumes: set pulses come from logic on clk_sys
// Notes: a set in the same cycle as a clearing write wins
module usbi_flag_bank #(
  parameter int W = 8,
  parameter logic [W-1:0] IMPL = '1,
  parameter bit SW_SET = 1'b0
) (
  input wire logic clk_sys, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic [W-1:0] set_evt, // engine set pulses
  input wire logic wr_en, // firmware write to this bank
  input wire logic [W-1:0] wdata, // write data, zero clears
  output logic [W-1:0] flags // flag outputs
);
  logic [W-1:0] flags_ff;
  logic [W-1:0] nxt_flags;

  // write zero clears; optional firmware set; engine set wins
  always_comb begin
    nxt_flags = flags_ff;
    if (wr_en) begin
      if (SW_SET) begin
        nxt_flags = wdata;
      end else begin
        nxt_flags = flags_ff & wdata;
      end
    end
    nxt_flags = (nxt_flags | set_evt) & IMPL;
  end

  // flag registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      flags_ff <= '0;
    end else if (ce) begin
      flags_ff <= nxt_flags;
    end
  end

  assign flags = flags_ff;
endmodule

// >>> logic/usbi_irq_ctrl.sv
// Purpose: usb status interrupt enables, error flags and interrupt request gating
// Assumes: engine event pulses and bus strobes come from logic on clk_sys
// Notes: read data stands one cycle after the read strobe
module usbi_irq_ctrl (
  input wire logic clk_sys, // 125 MHz system clock
  input wire logic resetn, // async reset, active low
  input wire logic ce, // clock enable, freezes state when low
  input wire logic [usbi_pkg::ADDR_W-1:0] addr, // register index
  input wire logic [usbi_pkg::REG_W-1:0] wdata, // write data
  input wire logic wr_stb, // write strobe
  input wire logic rd_stb, // read strobe
  output logic [usbi_pkg::REG_W-1:0] rdata, // read data, cycle after rd_stb
  input wire logic [usbi_pkg::REG_W-1:0] status_set_evt, // engine status pulses
  input wire logic [usbi_pkg::REG_W-1:0] err_set_evt, // engine error pulses
  output logic error_summary_flag, // enabled error present
  output logic usb_irq_request, // enabled status flag present
  output logic irq // unmasked event pending
);
  import usbi_pkg::*;

  logic [REG_W-1:0] stat_en_ff;
  logic [REG_W-1:0] nxt_stat_en;
  logic [REG_W-1:0] err_en_ff;
  logic [REG_W-1:0] nxt_err_en;
  logic [REG_W-1:0] evt_mask_ff;
  logic [REG_W-1:0] nxt_evt_mask;
  logic [REG_W-1:0] evt_ff;
  logic [REG_W-1:0] nxt_evt;
  logic [REG_W-1:0] rdata_ff;
  logic [REG_W-1:0] nxt_rdata;
  logic req_prev_ff;
  logic nxt_req_prev;
  logic [REG_W-1:0] stat_flags;
  logic [REG_W-1:0] err_flags;
  logic [REG_W-1:0] stat_view;
  logic [REG_W-1:0] evt_set;
  logic wr_stat_flag;
  logic wr_err_flag;

  // true when a strobe hits the given register index
  function automatic logic hit(input logic stb, input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] off);
    hit = stb && (a == off);
  endfunction

  assign wr_stat_flag = ce && hit(wr_stb, addr, OFF_STAT_FLAG);
  assign wr_err_flag = ce && hit(wr_stb, addr, OFF_ERR_FLAG);

  // status flags: firmware may set or clear, engine sets
  usbi_flag_bank #(
    .W(REG_W),
    .IMPL(STAT_FLAG_MASK),
    .SW_SET(1'b1)
  ) u_stat_bank (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .ce(ce),
    .set_evt(status_set_evt),
    .wr_en(wr_stat_flag),
    .wdata(wdata),
    .flags(stat_flags)
  );

  // error flags: engine sets, firmware clears by writing zero
  usbi_flag_bank #(
    .W(REG_W),
    .IMPL(ERR_MASK),
    .SW_SET(1'b0)
  ) u_err_bank (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .ce(ce),
    .set_evt(err_set_evt),
    .wr_en(wr_err_flag),
    .wdata(wdata),
    .flags(err_flags)
  );

  // error summary: each error gated by its enable, then ORed
  assign error_summary_flag = |(err_flags & err_en_ff);

  // status view holds the summary at its read-only position
  always_comb begin
    stat_view = stat_flags;
    stat_view[ST_ERR] = error_summary_flag;
  end

  // interrupt request: OR of each flag AND its enable, every cycle
  assign usb_irq_request = |(stat_view & stat_en_ff);

  // enable and mask registers next values
  always_comb begin
    nxt_stat_en = stat_en_ff;
    nxt_err_en = err_en_ff;
    nxt_evt_mask = evt_mask_ff;
    if (hit(wr_stb, addr, OFF_STAT_EN)) begin
      nxt_stat_en = wdata & STAT_EN_MASK;
    end
    if (hit(wr_stb, addr, OFF_ERR_EN)) begin
      nxt_err_en = wdata & ERR_MASK;
    end
    if (hit(wr_stb, addr, OFF_EVT_MASK)) begin
      nxt_evt_mask = wdata & EVT_MASK;
    end
  end

  // enable and mask registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      stat_en_ff <= REG_RST;
      err_en_ff <= REG_RST;
      evt_mask_ff <= REG_RST;
    end else if (ce) begin
      stat_en_ff <= nxt_stat_en;
      err_en_ff <= nxt_err_en;
      evt_mask_ff <= nxt_evt_mask;
    end
  end

  // event sources: any implemented status pulse, any implemented error pulse, rise of the request
  always_comb begin
    evt_set = '0;
    evt_set[EV_STAT] = |(status_set_evt & STAT_FLAG_MASK);
    evt_set[EV_ERR] = |(err_set_evt & ERR_MASK);
    evt_set[EV_REQ] = usb_irq_request && !req_prev_ff;
  end

  // sticky events, cleared by a read, a new event wins over the clear
  always_comb begin
    nxt_evt = evt_ff;
    nxt_req_prev = usb_irq_request;
    if (hit(rd_stb, addr, OFF_EVT)) begin
      nxt_evt = '0;
    end
    nxt_evt = nxt_evt | evt_set;
  end

  // event registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      evt_ff <= REG_RST;
      req_prev_ff <= 1'b0;
    end else if (ce) begin
      evt_ff <= nxt_evt;
      req_prev_ff <= nxt_req_prev;
    end
  end

  assign irq = |(evt_ff & evt_mask_ff);

  // read mux, unmapped indices read zero
  always_comb begin
    nxt_rdata = REG_RST;
    if (rd_stb) begin
      unique case (addr)
        OFF_STAT_FLAG: nxt_rdata = stat_view;
        OFF_STAT_EN: nxt_rdata = stat_en_ff;
        OFF_ERR_FLAG: nxt_rdata = err_flags;
        OFF_ERR_EN: nxt_rdata = err_en_ff;
        OFF_EVT: nxt_rdata = evt_ff;
        OFF_EVT_MASK: nxt_rdata = evt_mask_ff;
        default: nxt_rdata = REG_RST;
      endcase
    end
  end

  // read data register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdata_ff <= REG_RST;
    end else if (ce) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata = rdata_ff;

  // checks on the behaviour of the flags and the request
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  // error flag positions follow their engine pulses on the next edge
  a_stuff_sets: assert property (
    ce && err_set_evt[ER_STUFF] |=> err_flags[ER_STUFF])
    else $error("stuffing error flag did not set");

  a_turn_sets: assert property (
    ce && err_set_evt[ER_TURN] |=> err_flags[ER_TURN])
    else $error("turnaround flag did not set");

  a_align_sets: assert property (
    ce && err_set_evt[ER_ALIGN] |=> err_flags[ER_ALIGN])
    else $error("alignment flag did not set");

  a_crc16_sets: assert property (
    ce && err_set_evt[ER_CRC16] |=> err_flags[ER_CRC16])
    else $error("data crc flag did not set");

  a_crc5_sets: assert property (
    ce && err_set_evt[ER_CRC5] |=> err_flags[ER_CRC5])
    else $error("token crc flag did not set");

  a_pid_now: assert property (
    ce && err_set_evt[ER_PID] && !err_en_ff[ER_PID] |=> err_flags[ER_PID])
    else $error("pid flag not set on the next edge");

  // unimplemented bits stay zero
  a_unimpl_zero: assert property (
    !stat_en_ff[REG_W-1] && (err_flags & ~ERR_MASK) == '0)
    else $error("unimplemented bit is set");

  // a status flag sets with its enable clear
  a_poll_no_en: assert property (
    ce && status_set_evt[ST_SOF] && !stat_en_ff[ST_SOF] |=> stat_flags[ST_SOF])
    else $error("status flag needs its enable to set");

  // a set error flag holds until a zero is written to it
  a_flag_holds: assert property (
    err_flags[ER_TURN] && !(wr_err_flag && !wdata[ER_TURN])
    |=> err_flags[ER_TURN])
    else $error("error flag dropped without a clearing write");

  a_zero_clears: assert property (
    wr_err_flag && !wdata[ER_ALIGN] && !err_set_evt[ER_ALIGN]
    |=> !err_flags[ER_ALIGN])
    else $error("writing zero did not clear the flag");

  // enabled error reaches the summary and the request
  a_err_to_req: assert property (
    ce && err_set_evt[ER_CRC16] && err_en_ff[ER_CRC16] && stat_en_ff[ST_ERR] && !wr_stb
    |=> error_summary_flag && usb_irq_request)
    else $error("enabled error did not reach the request");

  // disabled errors never raise the summary
  a_masked_quiet: assert property (
    err_en_ff == '0 |-> !error_summary_flag && !stat_view[ST_ERR])
    else $error("summary raised with all error enables clear");

  // firmware cannot force the summary by a status write
  a_summary_ro: assert property (
    wr_stat_flag && wdata[ST_ERR] && err_flags == '0 && err_set_evt == '0
    |=> !stat_view[ST_ERR])
    else $error("summary set by a firmware write");

  // status event with enable set raises the request on the next edge
  a_req_follows: assert property (
    ce && status_set_evt[ST_URST] && stat_en_ff[ST_URST] && !wr_stb
    |=> usb_irq_request)
    else $error("enabled status flag did not raise the request");

  // request drops once every enable is cleared
  a_req_gated: assert property (
    stat_en_ff == '0 |-> !usb_irq_request)
    else $error("request raised with all enables clear");

  // read data of the enable register stands in the next cycle
  a_read_next: assert property (
    ce && rd_stb && addr == OFF_STAT_EN |=> rdata == $past(stat_en_ff))
    else $error("read data wrong one cycle after the strobe");

  // every status source sets its flag whatever its enable
  a_stall_polls: assert property (
    ce && status_set_evt[ST_STALL] |=> stat_flags[ST_STALL])
    else $error("stall flag did not set");

  a_idle_polls: assert property (
    ce && status_set_evt[ST_IDLE] |=> stat_flags[ST_IDLE])
    else $error("idle flag did not set");

  a_done_polls: assert property (
    ce && status_set_evt[ST_TRN] |=> stat_flags[ST_TRN])
    else $error("transfer done flag did not set");

  a_actv_polls: assert property (
    ce && status_set_evt[ST_ACTV] |=> stat_flags[ST_ACTV])
    else $error("bus activity flag did not set");

  a_urst_polls: assert property (
    ce && status_set_evt[ST_URST] |=> stat_flags[ST_URST])
    else $error("bus reset flag did not set");

  // firmware may set a status flag for debug
  a_stat_fw_set: assert property (
    wr_stat_flag && wdata[ST_STALL] |=> stat_flags[ST_STALL])
    else $error("firmware write did not set the status flag");

  // reserved positions read zero
  a_stat_bit7: assert property (
    !stat_view[REG_W-1])
    else $error("status bit 7 is set");

  a_err_en_resv: assert property (
    (err_en_ff & ~ERR_MASK) == '0)
    else $error("reserved error enable bit is set");

  // clearing every enable silences the request and the summary on the next edge
  a_req_drops: assert property (
    ce && wr_stb && addr == OFF_STAT_EN && wdata == '0
    |=> !usb_irq_request)
    else $error("request stayed up after its enables were cleared");

  a_summary_drops: assert property (
    ce && wr_stb && addr == OFF_ERR_EN && wdata == '0
    |=> !error_summary_flag)
    else $error("summary stayed up after error enables were cleared");

  // a low clock enable freezes every register
  a_ce_freeze: assert property (
    !ce |=> $stable(err_flags) && $stable(stat_flags) && $stable(stat_en_ff)
    && $stable(evt_ff) && $stable(rdata))
    else $error("state changed while the clock enable was low");

  // read data falls back to zero after a cycle with no read
  a_rdata_idle: assert property (
    ce && !rd_stb |=> rdata == REG_RST)
    else $error("read data stood without a read");

  // an event read clears the register unless a new event lands
  a_evt_clears: assert property (
    ce && rd_stb && addr == OFF_EVT && evt_set == '0
    |=> evt_ff == '0)
    else $error("event register not cleared by its read");

  a_evt_err_wins: assert property (
    ce && evt_set[EV_ERR] |=> evt_ff[EV_ERR])
    else $error("error event lost");

  a_evt_req_rise: assert property (
    ce && evt_set[EV_REQ] |=> evt_ff[EV_REQ])
    else $error("request rise event lost");

  // a cleared mask keeps the event interrupt low
  a_irq_masked: assert property (
    evt_mask_ff == '0 |-> !irq)
    else $error("interrupt raised with every event masked");

  // main scenarios
  c_err_irq: cover property (
    ce && err_set_evt[ER_STUFF] && err_en_ff[ER_STUFF] ##1 usb_irq_request);
  c_clear_flag: cover property (
    err_flags[ER_PID] ##1 wr_err_flag && !wdata[ER_PID] ##1 !err_flags[ER_PID]);
  c_set_vs_clear: cover property (
    wr_err_flag && !wdata[ER_CRC5] && err_set_evt[ER_CRC5]);
  c_evt_irq: cover property (evt_set[EV_REQ] && evt_mask_ff[EV_REQ] ##1 irq);
  c_status_req: cover property (
    ce && status_set_evt[ST_SOF] && stat_en_ff[ST_SOF] ##1 usb_irq_request);
endmodule

// >>> bench/usbi_eng_model.sv
// Purpose: serial engine stand-in that reports detected conditions as set pulses
// Assumes: one request from the bench per call, on clk_sys
// Notes: each report is a single-cycle pulse, so flags must hold it themselves
module usbi_eng_model (
  input wire logic clk_sys, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic fire, // report the conditions below
  input wire logic to_err, // 1 reports errors, 0 status events
  input wire logic [7:0] cond, // detected conditions
  output logic [7:0] status_set_evt, // status event pulses
  output logic [7:0] err_set_evt // error pulses
);
  timeunit 1ns;
  timeprecision 1ps;
  // report in the cycle after detection, never held until token end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      status_set_evt <= 8'h00;
      err_set_evt <= 8'h00;
    end else begin
      status_set_evt <= (fire && !to_err) ? cond : 8'h00;
      err_set_evt <= (fire && to_err) ? cond : 8'h00;
    end
  end
endmodule

// >>> bench/testbench.sv
// Purpose: self-checking bench of the usb interrupt enable and error status block
// Assumes: register reads are queued and compared by a watcher one cycle later
// Notes: random status enables and events come from a fixed seed
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import usbi_pkg::*;
  logic clk_sys, resetn, ce, wr_stb, rd_stb, fire, to_err, rd_d;
  logic [ADDR_W-1:0] addr;
  logic [REG_W-1:0] wdata, rdata, cond, st_evt, er_evt, en, ev, fl;
  logic error_summary_flag, usb_irq_request, irq;
  logic [11:0] exp_q[$];
  logic [11:0] note;
  int epos[6] = '{ER_STUFF, ER_TURN, ER_ALIGN, ER_CRC16, ER_CRC5, ER_PID};
  int error_cnt = 0;
  int comparisons = 0;

  usbi_irq_ctrl dut (.clk_sys(clk_sys), .resetn(resetn), .ce(ce), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .status_set_evt(st_evt), .err_set_evt(er_evt), .error_summary_flag(error_summary_flag),
    .usb_irq_request(usb_irq_request), .irq(irq));
  usbi_eng_model eng (.clk_sys(clk_sys), .resetn(resetn), .fire(fire), .to_err(to_err),
    .cond(cond), .status_set_evt(st_evt), .err_set_evt(er_evt));

  // 125 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // one-cycle bus write, taken at the closing edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
    #1;
  endtask

  // one-cycle bus read; the watcher compares the data
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    addr <= a;
    rd_stb <= 1'b1;
    exp_q.push_back({a, e});
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    #1;
  endtask

  // engine report, visible on the flags when this returns
  task automatic pulse(input logic k, input logic [7:0] c);
    @(posedge clk_sys);
    fire <= 1'b1;
    to_err <= k;
    cond <= c;
    @(posedge clk_sys);
    fire <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask

  // read data stands in the cycle after the strobe
  always @(posedge clk_sys) rd_d <= rd_stb & ce;
  always @(negedge clk_sys) begin
    if (rd_d === 1'b1) begin
      note = exp_q.pop_front();
      chk($sformatf("rdata idx %0h", note[11:8]), note[7:0], rdata);
    end
  end

  // watchdog: the tests need well under 2000 cycles
  initial begin
    #50000;
    error_cnt++;
    end_sim();
  end

  initial begin
    {resetn, addr, wdata, wr_stb, rd_stb, fire, to_err, cond} = '0;
    ce = 1'b1;
    void'($urandom(32'h7de0));
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int i = 0; i < 7; i++) rd((i == 6) ? 4'hf : 4'(i), 8'h00);
    $display("test reset_values done");
    @(posedge clk_sys);
    ce <= 1'b0;
    wr(OFF_STAT_EN, 8'hff);
    @(posedge clk_sys);
    ce <= 1'b1;
    rd(OFF_STAT_EN, 8'h00);
    wr(OFF_STAT_EN, 8'hff);
    rd(OFF_STAT_EN, 8'h7f);
    wr(OFF_EVT_MASK, 8'hff);
    rd(OFF_EVT_MASK, 8'h07);
    wr(OFF_ERR_FLAG, 8'hff);
    rd(OFF_ERR_FLAG, 8'h00);
    wr(OFF_STAT_FLAG, 8'h02);
    rd(OFF_STAT_FLAG, 8'h00);
    $display("test register_access done");
    for (int i = 0; i < 6; i++) begin
      pulse(1'b1, 8'h01 << epos[i]);
      chk("summary", 8'h00, 8'(error_summary_flag));
      chk("irq", 8'h01, 8'(irq));
      rd(OFF_ERR_FLAG, 8'h01 << epos[i]);
      wr(OFF_ERR_EN, 8'h01 << epos[i]);
      chk("summary", 8'h01, 8'(error_summary_flag));
      chk("request", 8'h01, 8'(usb_irq_request));
      wr(OFF_ERR_FLAG, 8'h00);
      chk("summary", 8'h00, 8'(error_summary_flag));
      rd(OFF_EVT, 8'h06);
      chk("irq", 8'h00, 8'(irq));
      wr(OFF_ERR_EN, 8'h00);
    end
    $display("test error_flags done");
    wr(OFF_ERR_EN, 8'h84);
    pulse(1'b1, 8'h84);
    chk("summary", 8'h01, 8'(error_summary_flag));
    chk("request", 8'h01, 8'(usb_irq_request));
    wr(OFF_ERR_EN, 8'h80);
    chk("summary", 8'h01, 8'(error_summary_flag));
    wr(OFF_ERR_FLAG, 8'h04);
    chk("summary", 8'h00, 8'(error_summary_flag));
    rd(OFF_ERR_FLAG, 8'h04);
    rd(OFF_EVT, 8'h06);
    wr(OFF_ERR_FLAG, 8'h00);
    wr(OFF_ERR_EN, 8'h00);
    $display("test enabled_errors done");
    for (int i = 0; i < 8; i++) begin
      en = 8'($urandom);
      ev = 8'($urandom) | 8'h40;
      wr(OFF_STAT_EN, en);
      pulse(1'b0, ev);
      fl = ev & STAT_FLAG_MASK;
      chk("request", 8'(|(fl & en)), 8'(usb_irq_request));
      rd(OFF_STAT_FLAG, fl);
      rd(OFF_EVT, {5'h00, |(fl & en), 2'b01});
      wr(OFF_STAT_FLAG, 8'h00);
      chk("request", 8'h00, 8'(usb_irq_request));
    end
    $display("test status_gating done");
    wr(OFF_STAT_EN, 8'h00);
    wr(OFF_EVT_MASK, 8'h00);
    pulse(1'b0, 8'h01);
    chk("irq", 8'h00, 8'(irq));
    wr(OFF_EVT_MASK, 8'h07);
    chk("irq", 8'h01, 8'(irq));
    rd(OFF_EVT, 8'h01);
    chk("irq", 8'h00, 8'(irq));
    $display("test event_mask done");
    repeat (3) @(posedge clk_sys);
    end_sim();
  end
endmodule
